// ===== design/lamp_hysteresis.sv
`timescale 1ns/100ps
`default_nettype none

// Two-threshold lamp detector, re-evaluated once per millisecond tick
module lamp_hysteresis
	import conflict_monitor_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic i_tick,
	input wire volt_t i_volts,
	input wire volt_t i_on_v,
	input wire volt_t i_off_v,
	output logic o_on
);

	logic on;
	logic next_on;

	always_comb begin
		next_on = on;
		if (i_tick) begin
			if (i_volts > i_on_v) begin
				next_on = 1'b1;
			end else if (i_volts < i_off_v) begin
				next_on = 1'b0;
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			on <= 1'b0;
		end else begin
			on <= next_on;
		end
	end

	assign o_on = on;

endmodule

`default_nettype wire

// ===== design/signal_conflict_monitor.sv
// Operation
// - Permissive pairs always hold both ways
// - Conflicting green/yellow pair starts conflict timer
// - Conflict gone: hold timer, run clear timer
// - Conflict back: zero clear timer, resume
// - Latch fault at 333 ms accumulated
// - Clear timer 666 ms zeroes conflict timer
// - Default red 70/50, green/yellow 25/15 thresholds
// - Fault drives relay, halt, indicator, logs
// - Fault held until reset; resets logged
// - Flashing red checking gated by coil sense
// - Excluded yellow ignored in all conflicts
// - Flashing red conflicts need 1500 ms
// - Arrow option ignores terminating and child yellows
// - Steady arrow loses permissive with opposing channel
// - Low-voltage option: all lamps 25/15
// - Reset acts once per activation
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "conflict_monitor_params.svh"

module signal_conflict_monitor
	import conflict_monitor_pkg::*;
#(
	parameter int CHANNELS = 16,
	parameter int TICK_CYCLES = `TICK_CYCLES
) (
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire apb_req_s i_apb,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire lamp_volts_s [CHANNELS-1:0] i_lamp,
	input wire volt_t i_flash_relay_coil_sense,
	input wire logic i_reset_button,
	input wire logic i_reset_input,
	output logic o_relay_fault,
	output logic o_controller_halt,
	output logic o_conflict_led
);

	if (CHANNELS < 2 || CHANNELS > 16) begin : g_bad_channels
		$error("CHANNELS must lie in 2..16");
	end
	if (TICK_CYCLES < 2 || TICK_CYCLES > 65536) begin : g_bad_tick
		$error("TICK_CYCLES must lie in 2..65536");
	end

	localparam logic [10:0] FAULT_MS = 11'(`CONFLICT_FAULT_MS);
	localparam logic [10:0] CLEAR_MS = 11'(`CONFLICT_CLEAR_MS);
	localparam logic [10:0] FLASH_FAULT_MS = 11'(`FLASH_RED_FAULT_MS);
	localparam logic [10:0] STEADY_MS = 11'(`ARROW_STEADY_MS);
	localparam logic [10:0] FLASH_WIN_MS = 11'(`RED_FLASH_WINDOW_MS);

	// Millisecond tick; lamp states settle on tick, timers step one cycle later
	logic [15:0] tick_cnt;
	logic [15:0] next_tick_cnt;
	logic tick;
	logic step;
	always_comb begin
		next_tick_cnt = (tick_cnt == 16'(TICK_CYCLES - 1)) ? 16'h0000 : tick_cnt + 16'h0001;
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			tick_cnt <= 16'h0000;
			tick <= 1'b0;
			step <= 1'b0;
		end else begin
			tick_cnt <= next_tick_cnt;
			tick <= (tick_cnt == 16'(TICK_CYCLES - 1));
			step <= tick;
		end
	end

	// Reset pins: two-stage synchronisers, then a rising-edge event
	logic [1:0] btn_sync;
	logic [1:0] rin_sync;
	logic rst_level;
	logic reset_evt;
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			btn_sync <= 2'b00;
			rin_sync <= 2'b00;
			rst_level <= 1'b0;
		end else begin
			btn_sync <= {btn_sync[0], i_reset_button};
			rin_sync <= {rin_sync[0], i_reset_input};
			rst_level <= btn_sync[1] | rin_sync[1];
		end
	end
	assign reset_evt = (btn_sync[1] | rin_sync[1]) & ~rst_level;

	// Registers
	logic [31:0] ctrl;
	logic [15:0] yel_excl;
	logic [15:0] active_ch;
	logic [15:0] perm_row [CHANNELS];
	logic [31:0] arrow_cfg [CHANNELS];
	logic [15:0] fault_count;
	logic [15:0] reset_count;

	logic wr_en;
	logic [3:0] ch_idx;
	assign wr_en = i_apb.psel & i_apb.penable & i_apb.pwrite & ~o_pready;
	assign ch_idx = i_apb.paddr[5:2];

	// Threshold selection
	volt_t red_on;
	volt_t red_off;
	assign red_on = ctrl[`CTRL_LOW_V_LAMP] ? 8'(`GY_ON_V) : 8'(`RED_ON_V);
	assign red_off = ctrl[`CTRL_LOW_V_LAMP] ? 8'(`GY_OFF_V) : 8'(`RED_OFF_V);

	logic [CHANNELS-1:0] red;
	logic [CHANNELS-1:0] yel;
	logic [CHANNELS-1:0] grn;
	logic [CHANNELS-1:0] red_flashing;
	logic [CHANNELS-1:0] arrow_steady;
	logic coil_on;

	lamp_hysteresis u_coil (
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.i_tick(tick),
		.i_volts(i_flash_relay_coil_sense),
		.i_on_v(8'(`COIL_ON_V)),
		.i_off_v(8'(`COIL_OFF_V)),
		.o_on(coil_on)
	);

	for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
		lamp_hysteresis u_red (
			.i_ref_clk(i_ref_clk),
			.i_srst(i_srst),
			.i_tick(tick),
			.i_volts(i_lamp[c].red),
			.i_on_v(red_on),
			.i_off_v(red_off),
			.o_on(red[c])
		);
		lamp_hysteresis u_yel (
			.i_ref_clk(i_ref_clk),
			.i_srst(i_srst),
			.i_tick(tick),
			.i_volts(i_lamp[c].yellow),
			.i_on_v(8'(`GY_ON_V)),
			.i_off_v(8'(`GY_OFF_V)),
			.o_on(yel[c])
		);
		lamp_hysteresis u_grn (
			.i_ref_clk(i_ref_clk),
			.i_srst(i_srst),
			.i_tick(tick),
			.i_volts(i_lamp[c].green),
			.i_on_v(8'(`GY_ON_V)),
			.i_off_v(8'(`GY_OFF_V)),
			.o_on(grn[c])
		);

		// Red change age marks a flashing red; yellow on-time marks a steady arrow
		logic red_prev;
		logic [10:0] red_age;
		logic [10:0] yel_on_ms;
		logic [10:0] next_red_age;
		logic [10:0] next_yel_on_ms;
		always_comb begin
			next_red_age = red_age;
			next_yel_on_ms = yel_on_ms;
			if (step) begin
				if (red[c] != red_prev) begin
					next_red_age = 11'h000;
				end else if (red_age < FLASH_WIN_MS) begin
					next_red_age = red_age + 11'h001;
				end
				if (!yel[c]) begin
					next_yel_on_ms = 11'h000;
				end else if (yel_on_ms != STEADY_MS) begin
					next_yel_on_ms = yel_on_ms + 11'h001;
				end
			end
		end
		always_ff @(posedge i_ref_clk) begin
			if (i_srst) begin
				red_prev <= 1'b0;
				red_age <= 11'h7ff;
				yel_on_ms <= 11'h000;
			end else begin
				red_prev <= step ? red[c] : red_prev;
				red_age <= next_red_age;
				yel_on_ms <= next_yel_on_ms;
			end
		end
		assign red_flashing[c] = red[c] && (red_age < FLASH_WIN_MS);
		assign arrow_steady[c] = (yel_on_ms == STEADY_MS) && (arrow_cfg[c][15:0] != 16'h0000);
	end

	// Unit-wide conflict evaluation over all channel pairs
	logic conflict;
	logic flash_inv;
	always_comb begin
		logic [CHANNELS-1:0] gy;
		logic [CHANNELS-1:0] fr;
		logic perm;
		logic yel_pair_ign;
		logic hit;
		gy = '0;
		fr = '0;
		perm = 1'b0;
		yel_pair_ign = 1'b0;
		hit = 1'b0;
		conflict = 1'b0;
		flash_inv = 1'b0;
		for (int i = 0; i < CHANNELS; i++) begin
			gy[i] = grn[i] | (yel[i] & ~yel_excl[i]);
			fr[i] = ctrl[`CTRL_PED_FLASH] & coil_on & active_ch[i] & red_flashing[i];
		end
		for (int i = 0; i < CHANNELS; i++) begin
			for (int j = i + 1; j < CHANNELS; j++) begin
				perm = perm_row[i][j] | perm_row[j][i];
				if (ctrl[`CTRL_ARROW] && ((arrow_steady[i] && arrow_cfg[i][j]) ||
						(arrow_steady[j] && arrow_cfg[j][i]))) begin
					perm = 1'b0;
				end
				yel_pair_ign = ctrl[`CTRL_ARROW] && ctrl[`CTRL_ARROW_YEL_IGN] &&
					(arrow_cfg[i][16 + j] || arrow_cfg[j][16 + i]) &&
					!grn[i] && !grn[j] && !fr[i] && !fr[j];
				hit = !perm && !yel_pair_ign && (gy[i] | fr[i]) && (gy[j] | fr[j]);
				conflict = conflict | hit;
				flash_inv = flash_inv | (hit && ((fr[i] && !gy[i]) || (fr[j] && !gy[j])));
			end
		end
	end

	// Hold-on-gap conflict timer, recovery timer and latched fault
	logic [10:0] conflict_ms;
	logic [10:0] clear_ms;
	logic fault;
	logic [10:0] next_conflict_ms;
	logic [10:0] next_clear_ms;
	logic next_fault;
	logic fault_set;
	logic [10:0] limit_ms;
	always_comb begin
		next_conflict_ms = conflict_ms;
		next_clear_ms = clear_ms;
		fault_set = 1'b0;
		limit_ms = flash_inv ? FLASH_FAULT_MS : FAULT_MS;
		if (step) begin
			if (conflict) begin
				next_clear_ms = 11'h000;
				if (conflict_ms != 11'h7ff) begin
					next_conflict_ms = conflict_ms + 11'h001;
				end
				fault_set = (conflict_ms + 11'h001) >= limit_ms;
			end else if (conflict_ms != 11'h000) begin
				if (clear_ms + 11'h001 >= CLEAR_MS) begin
					next_conflict_ms = 11'h000;
					next_clear_ms = 11'h000;
				end else begin
					next_clear_ms = clear_ms + 11'h001;
				end
			end
		end
		// Only a reset event clears the fault, and a new trip wins over it
		next_fault = fault_set | (fault & ~reset_evt);
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			conflict_ms <= 11'h000;
			clear_ms <= 11'h000;
			fault <= 1'b0;
		end else begin
			conflict_ms <= next_conflict_ms;
			clear_ms <= next_clear_ms;
			fault <= next_fault;
		end
	end

	// Outputs follow the latched fault
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			o_relay_fault <= 1'b0;
			o_controller_halt <= 1'b0;
			o_conflict_led <= 1'b0;
		end else begin
			o_relay_fault <= next_fault;
			o_controller_halt <= next_fault;
			o_conflict_led <= next_fault;
		end
	end

	// Register file with fault and reset logs
	logic [31:0] next_ctrl;
	logic [15:0] next_yel_excl;
	logic [15:0] next_active_ch;
	logic [15:0] next_fault_count;
	logic [15:0] next_reset_count;
	always_comb begin
		next_ctrl = ctrl;
		next_yel_excl = yel_excl;
		next_active_ch = active_ch;
		next_fault_count = fault_count;
		next_reset_count = reset_count;
		if (wr_en) begin
			case (i_apb.paddr)
				`REG_CTRL: next_ctrl = {28'h0000000, i_apb.pwdata[3:0]};
				`REG_YEL_EXCLUDE: next_yel_excl = i_apb.pwdata[15:0];
				`REG_ACTIVE: next_active_ch = i_apb.pwdata[15:0];
				default: next_ctrl = ctrl;
			endcase
		end
		if (fault_set && !fault) begin
			next_fault_count = fault_count + 16'h0001;
		end
		if (reset_evt) begin
			next_reset_count = reset_count + 16'h0001;
		end
	end

	logic [31:0] rd_word;
	logic rd_ok;
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_ok = 1'b1;
		if (i_apb.paddr >= `REG_PERM_BASE && i_apb.paddr < `REG_ARROW_BASE) begin
			rd_ok = (i_apb.paddr[1:0] == 2'b00) && (32'(ch_idx) < CHANNELS);
			rd_word = rd_ok ? {16'h0000, perm_row[ch_idx]} : 32'h0000_0000;
		end else if (i_apb.paddr >= `REG_ARROW_BASE && i_apb.paddr < 8'hc0) begin
			rd_ok = (i_apb.paddr[1:0] == 2'b00) && (32'(ch_idx) < CHANNELS);
			rd_word = rd_ok ? arrow_cfg[ch_idx] : 32'h0000_0000;
		end else begin
			case (i_apb.paddr)
				`REG_CTRL: rd_word = ctrl;
				`REG_YEL_EXCLUDE: rd_word = {16'h0000, yel_excl};
				`REG_ACTIVE: rd_word = {16'h0000, active_ch};
				`REG_STATUS: begin
					rd_word = {5'h00, conflict_ms, 12'h000, coil_on, flash_inv, conflict, fault};
				end
				`REG_LOG: rd_word = {reset_count, fault_count};
				default: rd_ok = 1'b0;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			ctrl <= `CTRL_RESET;
			yel_excl <= `YEL_EXCLUDE_RESET;
			active_ch <= `ACTIVE_RESET;
			fault_count <= 16'h0000;
			reset_count <= 16'h0000;
			for (int k = 0; k < CHANNELS; k++) begin
				perm_row[k] <= `PERM_RESET;
				arrow_cfg[k] <= `ARROW_RESET;
			end
			o_prdata <= 32'h0000_0000;
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			yel_excl <= next_yel_excl;
			active_ch <= next_active_ch;
			fault_count <= next_fault_count;
			reset_count <= next_reset_count;
			if (wr_en && rd_ok && 32'(ch_idx) < CHANNELS) begin
				if (i_apb.paddr >= `REG_PERM_BASE && i_apb.paddr < `REG_ARROW_BASE) begin
					perm_row[ch_idx] <= i_apb.pwdata[15:0];
				end else if (i_apb.paddr >= `REG_ARROW_BASE) begin
					arrow_cfg[ch_idx] <= i_apb.pwdata;
				end
			end
			o_pready <= i_apb.psel & i_apb.penable & ~o_pready;
			o_pslverr <= i_apb.psel & i_apb.penable & ~o_pready & ~rd_ok;
			o_prdata <= (i_apb.psel & i_apb.penable & ~o_pready & ~i_apb.pwrite) ?
				rd_word : 32'h0000_0000;
		end
	end

endmodule

`default_nettype wire

// ===== shared/conflict_monitor_params.svh
`ifndef CONFLICT_MONITOR_PARAMS_SVH
`define CONFLICT_MONITOR_PARAMS_SVH

// Clock and tick
`define REF_CLK_HZ 25000000
`define TICK_PERIOD_US 1000
`define TICK_CYCLES ((`REF_CLK_HZ / 1000000) * `TICK_PERIOD_US)

// Conflict timing, in milliseconds
`define CONFLICT_FAULT_MS 333
`define CONFLICT_CLEAR_MS 666
`define FLASH_RED_FAULT_MS 1500
`define ARROW_STEADY_MS 1000
`define RED_FLASH_WINDOW_MS 1200

// Lamp and flash relay coil thresholds, volts RMS
`define RED_ON_V 70
`define RED_OFF_V 50
`define GY_ON_V 25
`define GY_OFF_V 15
`define COIL_ON_V 70
`define COIL_OFF_V 50

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_YEL_EXCLUDE 8'h04
`define REG_ACTIVE 8'h08
`define REG_STATUS 8'h0c
`define REG_LOG 8'h10
`define REG_PERM_BASE 8'h40
`define REG_ARROW_BASE 8'h80

// Control field positions
`define CTRL_PED_FLASH 0
`define CTRL_ARROW 1
`define CTRL_ARROW_YEL_IGN 2
`define CTRL_LOW_V_LAMP 3

// Status field positions
`define STAT_FAULT 0
`define STAT_CONFLICT 1
`define STAT_FLASH_INV 2
`define STAT_COIL 3
`define STAT_TIMER_LSB 16

// Reset values
`define CTRL_RESET 32'h0000_0000
`define YEL_EXCLUDE_RESET 16'h0000
`define ACTIVE_RESET 16'h0000
`define PERM_RESET 16'h0000
`define ARROW_RESET 32'h0000_0000

`endif

// ===== shared/conflict_monitor_pkg.sv
package conflict_monitor_pkg;

	typedef logic [7:0] volt_t;

	typedef struct packed {
		volt_t red;
		volt_t yellow;
		volt_t green;
	} lamp_volts_s;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_s;

endpackage

// ===== test/field_model.sv
`timescale 1ns/100ps
`default_nettype none

// Field loads, all lit lamps at one common level
module field_model
	import conflict_monitor_pkg::*;
#(
	parameter int CHANNELS = 16
) (
	input wire logic [CHANNELS-1:0] i_green,
	input wire logic [CHANNELS-1:0] i_yellow,
	input wire logic [CHANNELS-1:0] i_red,
	input wire volt_t i_level,
	input wire volt_t i_coil_level,
	output var lamp_volts_s [CHANNELS-1:0] o_lamp,
	output var volt_t o_coil
);
	always_comb begin
		for (int i = 0; i < CHANNELS; i++) begin
			o_lamp[i].red = i_red[i] ? i_level : 8'h00;
			o_lamp[i].yellow = i_yellow[i] ? i_level : 8'h00;
			o_lamp[i].green = i_green[i] ? i_level : 8'h00;
		end
		o_coil = i_coil_level;
	end
endmodule

`default_nettype wire

// ===== test/signal_conflict_monitor_bench.sv
`timescale 1ns/100ps
`default_nettype none

module signal_conflict_monitor_bench;
	import conflict_monitor_pkg::*;
	localparam int T = 4;
	logic i_ref_clk = 1'b0;
	logic i_srst = 1'b1;
	apb_req_s i_apb = '0;
	logic [15:0] grn = 16'h0000;
	logic [15:0] yel = 16'h0000;
	volt_t lvl = 8'h1a;
	logic [15:0] red = 16'h0000;
	volt_t coil_lvl = 8'h00;
	logic btn = 1'b0;
	logic rin = 1'b0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic fault;
	logic halt;
	logic led;
	lamp_volts_s [15:0] lamp;
	volt_t coil;
	int mismatches = 0;
	int comparisons = 0;
	int n;
	logic [31:0] rd;
	logic err;
	logic [7:0] addrs [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h40, 8'h80};

	always #20 i_ref_clk = ~i_ref_clk;

	field_model i_field (.i_green(grn), .i_yellow(yel), .i_red(red), .i_level(lvl),
		.i_coil_level(coil_lvl), .o_lamp(lamp), .o_coil(coil));
	signal_conflict_monitor #(.TICK_CYCLES(T)) i_dut (
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.i_apb(i_apb),
		.o_prdata(prdata),
		.o_pready(pready),
		.o_pslverr(pslverr),
		.i_lamp(lamp),
		.i_flash_relay_coil_sense(coil),
		.i_reset_button(btn),
		.i_reset_input(rin),
		.o_relay_fault(fault),
		.o_controller_halt(halt),
		.o_conflict_led(led)
	);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		i_apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge i_ref_clk);
		i_apb.penable <= 1'b1;
		@(posedge i_ref_clk);
		while (pready !== 1'b1) @(posedge i_ref_clk);
		rd = prdata;
		err = pslverr;
		i_apb <= '0;
	endtask

	task automatic ticks(input int k);
		repeat (k * T) @(posedge i_ref_clk);
	endtask

	task automatic lamps(input logic [15:0] g, input logic [15:0] y);
		@(posedge i_ref_clk);
		grn <= g;
		yel <= y;
	endtask

	task automatic wait_fault();
		n = 0;
		while (fault !== 1'b1 && n < 2000) begin
			@(posedge i_ref_clk);
			n++;
		end
	endtask

	// Dark lamps long enough to drop held conflict time, then a reset event
	task automatic clear();
		lamps(16'h0000, 16'h0000);
		ticks(680);
		rin <= 1'b1;
		ticks(3);
		rin <= 1'b0;
		ticks(2);
		chk(fault, 0);
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		repeat (50000) @(posedge i_ref_clk);
		mismatches++;
		$display("BAD %0t watchdog expired", $time);
		tally_and_finish();
	end

	initial begin
		repeat (3) @(posedge i_ref_clk);
		i_srst <= 1'b0;
		foreach (addrs[i]) begin
			apb(1'b0, addrs[i], 32'h0);
			chk(rd, 0);
			chk(err, 0);
		end
		apb(1'b0, 8'h14, 32'h0);
		chk(err, 1);
		chk(rd, 0);
		$display("test registers done");

		lamps(16'h0003, 16'h0000);
		wait_fault();
		chk(n >= 333 * T + 1 && n <= 334 * T + 3, 1);
		chk(halt, 1);
		chk(led, 1);
		apb(1'b0, 8'h0c, 32'h0);
		chk(rd[0], 1);
		apb(1'b0, 8'h10, 32'h0);
		chk(rd[15:0], 1);
		$display("test trip timing done");

		lamps(16'h0000, 16'h0000);
		ticks(10);
		chk(fault, 1);
		btn <= 1'b1;
		ticks(2);
		chk(fault, 0);
		lamps(16'h0003, 16'h0000);
		wait_fault();
		chk(fault, 1);
		btn <= 1'b0;
		clear();
		apb(1'b0, 8'h10, 32'h0);
		chk(rd[31:16], 2);
		$display("test reset events done");

		lamps(16'h0003, 16'h0000);
		ticks(200);
		lamps(16'h0000, 16'h0000);
		ticks(100);
		chk(fault, 0);
		lamps(16'h0003, 16'h0000);
		ticks(140);
		chk(fault, 1);
		clear();
		lamps(16'h0003, 16'h0000);
		ticks(200);
		lamps(16'h0000, 16'h0000);
		ticks(700);
		lamps(16'h0003, 16'h0000);
		ticks(140);
		chk(fault, 0);
		clear();
		$display("test accumulation done");

		apb(1'b1, 8'h44, 32'h1);
		lamps(16'h0003, 16'h0000);
		ticks(400);
		chk(fault, 0);
		apb(1'b1, 8'h44, 32'h0);
		lamps(16'h0000, 16'h0000);
		lvl <= 8'h14;
		ticks(2);
		lamps(16'h0003, 16'h0000);
		ticks(400);
		chk(fault, 0);
		lamps(16'h0000, 16'h0000);
		lvl <= 8'h1a;
		ticks(2);
		$display("test permissive and threshold done");

		// Newly lit red on an active channel counts as flashing red
		apb(1'b1, 8'h00, 32'h1);
		apb(1'b1, 8'h08, 32'h1);
		lvl <= 8'h50;
		coil_lvl <= 8'h50;
		red <= 16'h0001;
		lamps(16'h0002, 16'h0000);
		ticks(400);
		chk(fault, 0);
		apb(1'b0, 8'h0c, 32'h0);
		chk(rd[3:1], 3'b111);
		coil_lvl <= 8'h00;
		ticks(2);
		apb(1'b0, 8'h0c, 32'h0);
		chk(rd[3:1], 3'b000);
		red <= 16'h0000;
		lvl <= 8'h1a;
		coil_lvl <= 8'h50;
		ticks(2);
		red <= 16'h0001;
		ticks(2);
		apb(1'b0, 8'h0c, 32'h0);
		chk(rd[2:1], 2'b00);
		apb(1'b1, 8'h00, 32'h9);
		ticks(2);
		apb(1'b0, 8'h0c, 32'h0);
		chk(rd[2:1], 2'b11);
		red <= 16'h0000;
		apb(1'b1, 8'h80, 32'h0002_0000);
		apb(1'b1, 8'h00, 32'h6);
		lamps(16'h0000, 16'h0003);
		ticks(2);
		apb(1'b0, 8'h0c, 32'h0);
		chk(rd[1], 0);
		apb(1'b1, 8'h00, 32'h2);
		apb(1'b0, 8'h0c, 32'h0);
		chk(rd[1], 1);
		apb(1'b1, 8'h00, 32'h0);
		apb(1'b1, 8'h08, 32'h0);
		apb(1'b1, 8'h80, 32'h0);
		coil_lvl <= 8'h00;
		clear();
		$display("test flashing red and arrow done");

		apb(1'b1, 8'h04, 32'h1);
		lamps(16'h0000, 16'h0003);
		ticks(400);
		chk(fault, 0);
		apb(1'b1, 8'h04, 32'h0);
		wait_fault();
		chk(fault, 1);
		$display("test yellow exclude done");
		tally_and_finish();
	end
endmodule

`default_nettype wire

// ===== test/signal_conflict_monitor_props.sv
`timescale 1ns/100ps
`default_nettype none

module signal_conflict_monitor_props
	import conflict_monitor_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire apb_req_s i_apb,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic i_reset_button,
	input wire logic i_reset_input,
	input wire logic o_relay_fault,
	input wire logic o_controller_halt,
	input wire logic o_conflict_led
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_srst);
	wire logic pin = i_reset_button || i_reset_input;

	property p_halt;
		o_controller_halt == o_relay_fault;
	endproperty
	a_halt: assert property (p_halt) else $error("halt differs");
	property p_led;
		o_conflict_led == o_relay_fault;
	endproperty
	a_led: assert property (p_led) else $error("led differs");
	// A fault only drops after a reset pin went high
	property p_held;
		$fell(o_relay_fault) |-> $past(pin, 2) || $past(pin, 3) || $past(pin, 4);
	endproperty
	a_held: assert property (p_held) else $error("fault dropped alone");
	property p_pulse;
		o_pready |=> !o_pready;
	endproperty
	a_pulse: assert property (p_pulse) else $error("ready too long");
	property p_answer;
		i_apb.psel && i_apb.penable && !o_pready |=> o_pready;
	endproperty
	a_answer: assert property (p_answer) else $error("ready late");
	property p_cause;
		o_pready |-> $past(i_apb.psel && i_apb.penable);
	endproperty
	a_cause: assert property (p_cause) else $error("ready unasked");
	property p_err;
		o_pslverr |-> o_pready;
	endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_idle;
		!o_pready |-> o_prdata == 32'h0;
	endproperty
	a_idle: assert property (p_idle) else $error("data while idle");
endmodule

bind signal_conflict_monitor signal_conflict_monitor_props i_props (
	.i_ref_clk(i_ref_clk),
	.i_srst(i_srst),
	.i_apb(i_apb),
	.o_prdata(o_prdata),
	.o_pready(o_pready),
	.o_pslverr(o_pslverr),
	.i_reset_button(i_reset_button),
	.i_reset_input(i_reset_input),
	.o_relay_fault(o_relay_fault),
	.o_controller_halt(o_controller_halt),
	.o_conflict_led(o_conflict_led)
);

`default_nettype wire
